// ---- rtl/sfl_pkg.sv ----
// Shared constants and types for the serial flash register-write and read block
package sfl_pkg;

  // System clock period, used to turn times into cycle counts
  localparam int CLK_PERIOD_NS = 5;

  // Opcodes
  localparam logic [7:0] OP_REG_WRITE   = 8'h01;
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_FAST_READ   = 8'h0b;

  // Array geometry
  localparam int ADDR_W    = 24;
  localparam int MEM_AW    = 8;
  localparam int MEM_DEPTH = 256;
  localparam int BLK_SHIFT = 16;

  // Frame field lengths, in serial bits or clock cycles
  localparam logic [5:0] OPCODE_BITS      = 6'h08;
  localparam logic [5:0] ADDR_BITS        = 6'h18;
  localparam logic [5:0] DUMMY_CYC_SINGLE = 6'h08;
  localparam logic [5:0] DUMMY_CYC_QUAD   = 6'h04;
  localparam logic [5:0] STEP_SINGLE      = 6'h01;
  localparam logic [5:0] STEP_QUAD        = 6'h04;
  localparam logic [4:0] WR_BITS_SHORT    = 5'h08;
  localparam logic [4:0] WR_BITS_LONG     = 5'h10;
  localparam logic [4:0] WR_BITS_SAT      = 5'h1f;

  // Values after reset
  localparam logic       TB_RESET    = 1'b0;
  localparam logic [3:0] PROT_RESET  = 4'h0;
  localparam logic [2:0] DRIVE_RESET = 3'h7;

  // Status byte layout
  localparam int ST_BUSY     = 0;
  localparam int ST_LATCH    = 1;
  localparam int ST_PROT_LSB = 2;
  localparam int ST_QUAD     = 6;

  // Configuration byte layout
  localparam int CFG_DRIVE_LSB = 0;
  localparam int CFG_TB        = 3;

  // Output enables of the four data lines
  localparam logic [3:0] OE_NONE   = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD   = 4'hf;

  typedef enum logic [2:0] {
    PH_CMD    = 3'b000,
    PH_ADDR   = 3'b001,
    PH_DUMMY  = 3'b010,
    PH_DATA   = 3'b011,
    PH_WRDATA = 3'b100,
    PH_IGNORE = 3'b101
  } sfl_phase_t;

endpackage

// ---- rtl/sfl_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module sfl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sfl_prot_chk.sv ----
// Protected-region check from the protect level and the top/bottom select
`timescale 1ns/10ps
`default_nettype none
module sfl_prot_chk (
  input  wire logic [23:0] addr,
  input  wire logic [3:0]  protectLevelBits,
  input  wire logic        topBottomSelect,
  output logic             protHit
);
  logic [8:0] sizeBlk;
  logic [8:0] blk;

  // Level n covers 2^(n-1) blocks of 64 KiB, level 9 and up the whole array
  always_comb begin
    blk = {1'b0, addr[23:sfl_pkg::BLK_SHIFT]};
    if (protectLevelBits == 4'h0) begin
      sizeBlk = 9'h000;
    end else if (protectLevelBits >= 4'h9) begin
      sizeBlk = 9'h100;
    end else begin
      sizeBlk = 9'h001 << (protectLevelBits - 4'h1);
    end
    if (topBottomSelect) begin
      protHit = blk < sizeBlk;
    end else begin
      protHit = (blk + sizeBlk) >= 9'h100;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sfl_regwrite_read.sv ----
// Serial flash command logic: register write, array protection, plain and fast read
// Operation
// - Top/bottom select is OTP, 0 top, 1 bottom
// - Top/bottom changes only via register write
// - Register write needs write latch set first
// - Reject write unless ended after 8/16 bits
// - Write cycle starts when chip select rises
// - Busy during cycle; then clear busy and latch
// - Busy bit readable during the write cycle
// - Protect level writable when latch is set
// - Refuse programming inside the protected region
// - Plain read samples rising, drives falling edge
// - Address increments per byte, wraps to zero
// - Read is opcode, 3-byte address, then data
// - Plain read only in single-line mode
// - Single fast read has one dummy byte
// - Quad fast read: 2, 6, 4 cycles
// - Fast read rejected while write cycle busy
// - Protect level bits default to zero
// - Drive strength loads 30-ohm default at reset
`timescale 1ns/10ps
`default_nettype none
module sfl_regwrite_read #(
  parameter int WRITE_CYCLE_NS = 1000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        serialClk,
  input  wire logic        chipSelectN,
  input  wire logic [3:0]  quadDataLinesIn,
  output logic      [3:0]  quadDataLinesOut,
  output logic      [3:0]  quadDataLinesOe,
  input  wire logic        quadCommandMode,
  input  wire logic        progReq,
  input  wire logic [23:0] progAddr,
  input  wire logic [7:0]  progData,
  output logic             progRefused,
  output logic             busyBit,
  output logic             writeEnableLatchBit,
  output logic      [3:0]  protectLevelBits,
  output logic             topBottomSelect,
  output logic      [2:0]  driveStrengthSel
);
  localparam int TW_CYC_RAW = WRITE_CYCLE_NS / sfl_pkg::CLK_PERIOD_NS;
  localparam int TW_CYC     = (TW_CYC_RAW < 1) ? 1 : TW_CYC_RAW;
  localparam logic [19:0] TW_LOAD = 20'(TW_CYC - 1);

  // ---------------- Link side, on the serial clock ----------------
  sfl_pkg::sfl_phase_t phase_reg;
  logic [5:0]  bitCnt_reg;
  logic [7:0]  opShift_reg;
  logic [23:0] addr_reg;
  logic        fastRd_reg;
  logic        statusRd_reg;
  logic [7:0]  recOp_reg;
  logic        recOpValid_reg;
  logic [4:0]  recBits_reg;
  logic [15:0] recData_reg;
  logic        recTag_reg;
  logic [7:0]  statusSync;
  logic        quadSync;
  logic [5:0]  step;
  logic [5:0]  bitNext;
  logic [7:0]  opNext;
  logic [23:0] addrNext;
  logic [15:0] wrNext;
  logic [5:0]  dummyCyc;

  // ---------------- System side ----------------
  logic        csSync;
  logic        csPrev_reg;
  logic        csRise;
  logic        usedTag_reg;
  logic [19:0] timer_reg;
  logic [7:0]  pendStatus_reg;
  logic [7:0]  pendCfg_reg;
  logic        pendHasCfg_reg;
  logic        wrLenOk;
  logic        protHit;
  logic [7:0]  statusByte;
  logic [7:0]  protDriveCfg;
  logic [7:0]  memArr [0:sfl_pkg::MEM_DEPTH-1];

  assign statusByte = {1'b0, 1'b1, protectLevelBits, writeEnableLatchBit, busyBit};
  assign protDriveCfg = {4'h0, topBottomSelect, driveStrengthSel};

  // Status and mode levels enter the link domain through two flops
  sfl_sync #(.W(8)) statusSyncU (
    .clk (serialClk),
    .rst (rst),
    .d   (statusByte),
    .q   (statusSync)
  );

  sfl_sync #(.W(1)) quadSyncU (
    .clk (serialClk),
    .rst (rst),
    .d   (quadCommandMode),
    .q   (quadSync)
  );

  // Quad mode moves four bits per clock, upper line first
  always_comb begin
    step     = quadSync ? sfl_pkg::STEP_QUAD : sfl_pkg::STEP_SINGLE;
    dummyCyc = quadSync ? sfl_pkg::DUMMY_CYC_QUAD : sfl_pkg::DUMMY_CYC_SINGLE;
    bitNext  = bitCnt_reg + step;
    if (quadSync) begin
      opNext   = {opShift_reg[3:0], quadDataLinesIn};
      addrNext = {addr_reg[19:0], quadDataLinesIn};
      wrNext   = {recData_reg[11:0], quadDataLinesIn};
    end else begin
      opNext   = {opShift_reg[6:0], quadDataLinesIn[0]};
      addrNext = {addr_reg[22:0], quadDataLinesIn[0]};
      wrNext   = {recData_reg[14:0], quadDataLinesIn[0]};
    end
  end

  // Frame sequencer; chip select high returns it to the opcode phase
  always_ff @(posedge serialClk or posedge rst or posedge chipSelectN) begin
    if (rst || chipSelectN) begin
      phase_reg    <= sfl_pkg::PH_CMD;
      bitCnt_reg   <= 6'h00;
      opShift_reg  <= 8'h00;
      addr_reg     <= 24'h000000;
      fastRd_reg   <= 1'b0;
      statusRd_reg <= 1'b0;
    end else begin
      case (phase_reg)
        sfl_pkg::PH_CMD: begin
          opShift_reg <= opNext;
          bitCnt_reg  <= bitNext;
          if (bitNext == sfl_pkg::OPCODE_BITS) begin
            bitCnt_reg <= 6'h00;
            case (opNext)
              sfl_pkg::OP_READ: begin
                phase_reg <= quadSync ? sfl_pkg::PH_IGNORE : sfl_pkg::PH_ADDR;
              end
              sfl_pkg::OP_FAST_READ: begin
                fastRd_reg <= 1'b1;
                // Reading during a write cycle would return stale array data
                phase_reg  <= statusSync[sfl_pkg::ST_BUSY] ? sfl_pkg::PH_IGNORE
                                                           : sfl_pkg::PH_ADDR;
              end
              sfl_pkg::OP_STATUS_READ: begin
                statusRd_reg <= 1'b1;
                phase_reg    <= sfl_pkg::PH_DATA;
              end
              sfl_pkg::OP_REG_WRITE: begin
                phase_reg <= sfl_pkg::PH_WRDATA;
              end
              default: begin
                phase_reg <= sfl_pkg::PH_IGNORE;
              end
            endcase
          end
        end
        sfl_pkg::PH_ADDR: begin
          addr_reg   <= addrNext;
          bitCnt_reg <= bitNext;
          if (bitNext == sfl_pkg::ADDR_BITS) begin
            bitCnt_reg <= 6'h00;
            phase_reg  <= fastRd_reg ? sfl_pkg::PH_DUMMY : sfl_pkg::PH_DATA;
          end
        end
        sfl_pkg::PH_DUMMY: begin
          bitCnt_reg <= bitCnt_reg + 6'h01;
          if (bitCnt_reg + 6'h01 == dummyCyc) begin
            phase_reg <= sfl_pkg::PH_DATA;
          end
        end
        sfl_pkg::PH_WRDATA, sfl_pkg::PH_DATA, sfl_pkg::PH_IGNORE: begin
          phase_reg <= phase_reg;
        end
        default: begin
          phase_reg <= sfl_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  // Command record survives chip select rising so the system side can judge it
  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      recTag_reg     <= 1'b0;
      recOp_reg      <= 8'h00;
      recOpValid_reg <= 1'b0;
      recBits_reg    <= 5'h00;
      recData_reg    <= 16'h0000;
    end else begin
      if (phase_reg == sfl_pkg::PH_CMD && bitCnt_reg == 6'h00) begin
        recOpValid_reg <= 1'b0;
        recBits_reg    <= 5'h00;
      end
      if (phase_reg == sfl_pkg::PH_CMD && bitNext == sfl_pkg::OPCODE_BITS) begin
        recOp_reg      <= opNext;
        recOpValid_reg <= 1'b1;
        recTag_reg     <= ~recTag_reg;
      end
      if (phase_reg == sfl_pkg::PH_WRDATA) begin
        recData_reg <= wrNext;
        // Saturating count keeps an overlong write from aliasing to 8 or 16
        if (recBits_reg > 5'h14) begin
          recBits_reg <= sfl_pkg::WR_BITS_SAT;
        end else begin
          recBits_reg <= recBits_reg + step[4:0];
        end
      end
    end
  end

  // Output path on the falling edge
  logic [7:0]  outShift_reg;
  logic [2:0]  outCnt_reg;
  logic [23:0] rdAddr_reg;
  logic        loaded_reg;
  logic [23:0] curAddr;
  logic [7:0]  curByte;

  // The array load port ignores chip select, so reading it here is quasi-static only if loads avoid a read
  always_comb begin
    curAddr = loaded_reg ? rdAddr_reg : addr_reg;
    curByte = statusRd_reg ? statusSync : memArr[curAddr[sfl_pkg::MEM_AW-1:0]];
  end

  always_ff @(negedge serialClk or posedge rst or posedge chipSelectN) begin
    if (rst || chipSelectN) begin
      quadDataLinesOut <= 4'h0;
      quadDataLinesOe  <= sfl_pkg::OE_NONE;
      outShift_reg     <= 8'h00;
      outCnt_reg       <= 3'h0;
      rdAddr_reg       <= 24'h000000;
      loaded_reg       <= 1'b0;
    end else if (phase_reg == sfl_pkg::PH_DATA) begin
      quadDataLinesOe <= quadSync ? sfl_pkg::OE_QUAD : sfl_pkg::OE_SINGLE;
      if (outCnt_reg == 3'h0) begin
        rdAddr_reg <= curAddr + 24'h000001;
        loaded_reg <= 1'b1;
        if (quadSync) begin
          quadDataLinesOut <= curByte[7:4];
          outShift_reg     <= {curByte[3:0], 4'h0};
          outCnt_reg       <= 3'h1;
        end else begin
          quadDataLinesOut <= {2'b00, curByte[7], 1'b0};
          outShift_reg     <= {curByte[6:0], 1'b0};
          outCnt_reg       <= 3'h7;
        end
      end else begin
        outCnt_reg <= outCnt_reg - 3'h1;
        if (quadSync) begin
          quadDataLinesOut <= outShift_reg[7:4];
          outShift_reg     <= {outShift_reg[3:0], 4'h0};
        end else begin
          quadDataLinesOut <= {2'b00, outShift_reg[7], 1'b0};
          outShift_reg     <= {outShift_reg[6:0], 1'b0};
        end
      end
    end else begin
      quadDataLinesOut <= 4'h0;
      quadDataLinesOe  <= sfl_pkg::OE_NONE;
    end
  end

  // ---------------- System clock side ----------------
  // Select is synchronised inverted so its reset value matches the idle pin
  sfl_sync #(.W(1)) csSyncU (
    .clk (clk),
    .rst (rst),
    .d   (~chipSelectN),
    .q   (csSync)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csPrev_reg <= 1'b0;
    end else begin
      csPrev_reg <= csSync;
    end
  end

  // A frame without clocks must not replay the previous command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      usedTag_reg <= 1'b0;
    end else if (csRise) begin
      usedTag_reg <= recTag_reg;
    end
  end

  assign csRise  = ~csSync & csPrev_reg;
  assign wrLenOk = (recBits_reg == sfl_pkg::WR_BITS_SHORT) ||
                   (recBits_reg == sfl_pkg::WR_BITS_LONG);

  // Latch, busy, timer and the register contents
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyBit             <= 1'b0;
      writeEnableLatchBit <= 1'b0;
      timer_reg           <= 20'h00000;
      pendStatus_reg      <= 8'h00;
      pendCfg_reg         <= 8'h00;
      pendHasCfg_reg      <= 1'b0;
      protectLevelBits    <= sfl_pkg::PROT_RESET;
      topBottomSelect     <= sfl_pkg::TB_RESET;
      driveStrengthSel    <= sfl_pkg::DRIVE_RESET;
    end else if (busyBit) begin
      if (timer_reg == 20'h00000) begin
        busyBit             <= 1'b0;
        writeEnableLatchBit <= 1'b0;
        protectLevelBits    <= pendStatus_reg[sfl_pkg::ST_PROT_LSB +: 4];
        if (pendHasCfg_reg) begin
          driveStrengthSel <= pendCfg_reg[sfl_pkg::CFG_DRIVE_LSB +: 3];
          // One-time bit: once set only reset returns it to zero
          topBottomSelect  <= topBottomSelect | pendCfg_reg[sfl_pkg::CFG_TB];
        end
      end else begin
        timer_reg <= timer_reg - 20'h00001;
      end
    end else if (csRise && recOpValid_reg && (recTag_reg != usedTag_reg)) begin
      if (recOp_reg == sfl_pkg::OP_LATCH_SET) begin
        writeEnableLatchBit <= 1'b1;
      end else if (recOp_reg == sfl_pkg::OP_REG_WRITE && writeEnableLatchBit && wrLenOk) begin
        busyBit   <= 1'b1;
        timer_reg <= TW_LOAD;
        if (recBits_reg == sfl_pkg::WR_BITS_LONG) begin
          pendStatus_reg <= recData_reg[15:8];
          pendCfg_reg    <= recData_reg[7:0];
          pendHasCfg_reg <= 1'b1;
        end else begin
          pendStatus_reg <= recData_reg[7:0];
          pendCfg_reg    <= protDriveCfg;
          pendHasCfg_reg <= 1'b0;
        end
      end
    end
  end

  sfl_prot_chk protChkU (
    .addr             (progAddr),
    .protectLevelBits (protectLevelBits),
    .topBottomSelect  (topBottomSelect),
    .protHit          (protHit)
  );

  // Array load port; a protected address outside a write cycle is refused and flagged for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      progRefused <= 1'b0;
    end else begin
      progRefused <= progReq && !busyBit && protHit;
    end
  end

  always_ff @(posedge clk) begin
    if (progReq && !busyBit && !protHit) begin
      memArr[progAddr[sfl_pkg::MEM_AW-1:0]] <= progData;
    end
  end

endmodule
`default_nettype wire

// ---- verification/sfl_regwrite_read_checker.sv ----
// Port-level assertions for the flash register-write and read block
`timescale 1ns/10ps
`default_nettype none
module sfl_regwrite_read_checker #(
  parameter int WRITE_CYCLE_NS = 1000
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       serialClk,
  input wire logic       chipSelectN,
  input wire logic [3:0] quadDataLinesOut,
  input wire logic [3:0] quadDataLinesOe,
  input wire logic       quadCommandMode,
  input wire logic       progReq,
  input wire logic       progRefused,
  input wire logic       busyBit,
  input wire logic       writeEnableLatchBit,
  input wire logic [3:0] protectLevelBits,
  input wire logic       topBottomSelect
);
  localparam int TW = WRITE_CYCLE_NS / sfl_pkg::CLK_PERIOD_NS;
  int busyCnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= busyBit ? busyCnt + 1 : 0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Small slack both ways covers the crossing and edge detect
  busy_len_a: assert property ($fell(busyBit) |-> busyCnt >= TW - 1 && busyCnt <= TW + 2)
    else $error("busy length wrong");
  latch_clear_a: assert property ($fell(busyBit) |-> ##[0:1] !writeEnableLatchBit)
    else $error("latch not cleared after write");
  busy_latch_a: assert property ($rose(busyBit) |-> $past(writeEnableLatchBit))
    else $error("write started without latch");
  busy_start_a: assert property ($rose(busyBit) |-> chipSelectN && !$past(chipSelectN, 7))
    else $error("write not started by frame end");
  prot_hold_a: assert property ($changed(protectLevelBits) |-> $past(busyBit) || $past(busyBit, 2))
    else $error("protect level changed outside write");
  tb_otp_a: assert property ($changed(topBottomSelect) |-> $rose(topBottomSelect) && $past(busyBit))
    else $error("top bottom select changed wrongly");
  refuse_a: assert property (progRefused |-> $past(progReq) && $past(protectLevelBits) != 4'h0)
    else $error("program refused without protection");
  oe_idle_a: assert property (chipSelectN |-> quadDataLinesOe == sfl_pkg::OE_NONE)
    else $error("lines driven while deselected");
  oe_mode_a: assert property (quadDataLinesOe != sfl_pkg::OE_NONE |->
    quadDataLinesOe == (quadCommandMode ? sfl_pkg::OE_QUAD : sfl_pkg::OE_SINGLE))
    else $error("enable does not match mode");
  out_edge_a: assert property (!chipSelectN && $changed(quadDataLinesOut) |-> !serialClk)
    else $error("data changed off falling edge");
endmodule

bind sfl_regwrite_read sfl_regwrite_read_checker #(.WRITE_CYCLE_NS(WRITE_CYCLE_NS)) chk_u (
  .clk(clk), .rst(rst), .serialClk(serialClk), .chipSelectN(chipSelectN),
  .quadDataLinesOut(quadDataLinesOut), .quadDataLinesOe(quadDataLinesOe),
  .quadCommandMode(quadCommandMode), .progReq(progReq), .progRefused(progRefused),
  .busyBit(busyBit), .writeEnableLatchBit(writeEnableLatchBit),
  .protectLevelBits(protectLevelBits), .topBottomSelect(topBottomSelect));
`default_nettype wire

// ---- verification/sfl_host_model.sv ----
// Host controller model for the flash serial link
`timescale 1ns/10ps
`default_nettype none
module sfl_host_model (
  output logic            serialClk,
  output logic            chipSelectN,
  output logic      [3:0] quadDataLinesIn,
  input  wire logic [3:0] quadDataLinesOut,
  input  wire logic [3:0] quadDataLinesOe
);
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    quadDataLinesIn = 4'h0;
  end

  // Clock stands low between frames; released lines toggle so stale values never pass
  task automatic frame(input logic [63:0] tx, input int txCyc, input bit quad,
                       input int rxCyc, output logic [63:0] rx);
    logic [3:0] v;
    rx = '0;
    chipSelectN = 1'b0;
    #21.3;
    for (int i = 0; i < txCyc + rxCyc; i++) begin
      if (i < txCyc) begin
        quadDataLinesIn = quad ? tx[63-4*i -: 4] : {3'h0, tx[63-i]};
      end else begin
        quadDataLinesIn = ~quadDataLinesIn;
      end
      #32 serialClk = 1'b1;
      for (int k = 0; k < 4; k++) v[k] = quadDataLinesOe[k] ? quadDataLinesOut[k] : 1'bz;
      if (i >= txCyc) rx = quad ? {rx[59:0], v} : {rx[62:0], v[1]};
      #32 serialClk = 1'b0;
    end
    #10 chipSelectN = 1'b1;
    #40;
  endtask
endmodule
`default_nettype wire

// ---- verification/test_sfl_regwrite_read.sv ----
// Self-checking bench for the flash register-write and read block
`timescale 1ns/10ps
`default_nettype none
module test_sfl_regwrite_read;
  logic        clk, rst, serialClk, chipSelectN, quadCommandMode, progReq, progRefused;
  logic        busyBit, writeEnableLatchBit, topBottomSelect;
  logic [3:0]  quadDataLinesIn, quadDataLinesOut, quadDataLinesOe, protectLevelBits;
  logic [23:0] progAddr;
  logic [7:0]  progData;
  logic [2:0]  driveStrengthSel;
  logic [63:0] rx;
  logic [7:0]  mem [256];
  int          errors, n_tests, mProt, mTb, mDrive, mLatch;

  // Long write cycle so busy spans a status read and a refused read
  sfl_regwrite_read #(.WRITE_CYCLE_NS(8000)) dut_u (.clk(clk), .rst(rst), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .quadDataLinesIn(quadDataLinesIn),
    .quadDataLinesOut(quadDataLinesOut), .quadDataLinesOe(quadDataLinesOe),
    .quadCommandMode(quadCommandMode), .progReq(progReq), .progAddr(progAddr),
    .progData(progData), .progRefused(progRefused), .busyBit(busyBit),
    .writeEnableLatchBit(writeEnableLatchBit), .protectLevelBits(protectLevelBits),
    .topBottomSelect(topBottomSelect), .driveStrengthSel(driveStrengthSel));
  sfl_host_model host_u (.serialClk(serialClk), .chipSelectN(chipSelectN),
    .quadDataLinesIn(quadDataLinesIn), .quadDataLinesOut(quadDataLinesOut),
    .quadDataLinesOe(quadDataLinesOe));

  always #2.5 clk = ~clk;

  task automatic test_done();
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpRegs();
    cmp({protectLevelBits, topBottomSelect, driveStrengthSel, writeEnableLatchBit, busyBit},
        {mProt[3:0], mTb[0], mDrive[2:0], mLatch[0], 1'b0});
  endtask

  function automatic bit hit(input logic [23:0] a);
    int sz;
    sz = (mProt >= 9) ? 256 : (mProt == 0) ? 0 : 1 << (mProt - 1);
    return mTb[0] ? (a[23:16] < sz) : (a[23:16] >= 256 - sz);
  endfunction

  task automatic prog(input logic [23:0] a, input logic [7:0] d);
    @(negedge clk);
    progReq = 1'b1;
    progAddr = a;
    progData = d;
    @(negedge clk);
    progReq = 1'b0;
    cmp(progRefused, hit(a));
    if (!hit(a)) mem[a[7:0]] = d;
  endtask

  task automatic regwr(input logic [63:0] tx, input int n, input bit ok);
    host_u.frame({8'h06, 56'h0}, 8, 0, 0, rx);
    mLatch = 1;
    cmpRegs();
    host_u.frame(tx, n, 0, 0, rx);
    if (ok) begin
      host_u.frame({8'h05, 56'h0}, 8, 0, 8, rx);
      cmp(rx[7:0], {2'b01, mProt[3:0], 2'b11});
      host_u.frame({8'h0b, 56'h0}, 40, 0, 8, rx);
      cmp(rx[7:0], 8'hzz);
      for (int i = 0; i < 3000 && busyBit !== 1'b0; i++) @(negedge clk);
      mProt = tx[53:50];
      if (n == 24) mDrive = tx[42:40];
      if (n == 24) mTb = mTb | tx[43];
      mLatch = 0;
    end else begin
      #200;
    end
    cmpRegs();
  endtask

  task automatic rd(input logic [7:0] op, input logic [23:0] a, input bit quad, input bit ok);
    host_u.frame({op, a, 32'h0}, quad ? 12 : (op == 8'h03 ? 32 : 40), quad,
                 quad ? 4 : 16, rx);
    cmp(rx[15:0], ok ? {mem[a[7:0]], mem[a[7:0] + 8'h1]} : 16'hzzzz);
  endtask

  initial begin
    #300000;
    errors++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    quadCommandMode = 1'b0;
    progReq = 1'b0;
    progAddr = 24'h0;
    progData = 8'h0;
    errors = 0;
    n_tests = 0;
    mProt = 0;
    mTb = 0;
    mDrive = 7;
    mLatch = 0;
    void'($urandom(32'ha25a8f90));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    cmpRegs();
    for (int a = 0; a < 256; a++) prog(a[23:0], 8'($urandom));
    host_u.frame({8'h01, 8'h3c, 48'h0}, 16, 0, 0, rx);
    #200 cmpRegs();
    regwr({8'h01, 8'h3c, 48'h0}, 20, 0);
    regwr({8'h01, 8'h1c, 8'h0d, 40'h0}, 24, 1);
    repeat (16) prog(24'($urandom), 8'($urandom));
    regwr({8'h01, 8'h24, 48'h0}, 16, 1);
    repeat (4) prog(24'($urandom), 8'h5a);
    regwr({8'h01, 8'h00, 8'h07, 40'h0}, 24, 1);
    rd(8'h03, 24'hffffff, 0, 1);
    rd(8'h0b, 24'($urandom), 0, 1);
    @(negedge clk) quadCommandMode = 1'b1;
    host_u.frame('1, 8, 0, 0, rx);
    rd(8'h0b, 24'($urandom), 1, 1);
    rd(8'h03, 24'($urandom), 1, 0);
    @(negedge clk) quadCommandMode = 1'b0;
    host_u.frame('1, 8, 0, 0, rx);
    rd(8'h03, 24'($urandom), 0, 1);
    test_done();
  end
endmodule
`default_nettype wire
